// ### rtl/dlsu_pkg.sv
package dlsu_pkg;

    // ============================================================
    // widths
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned ADDR_W        = 32;
    localparam int unsigned BND_DEPTH     = 16;
    localparam int unsigned BND_IDX_W     = 4;

    // ============================================================
    // reserved region geometry
    localparam int unsigned PAGE_LSB      = 12;           // 4 kbyte user page
    localparam int unsigned REGION_LSB    = 13;           // 8 kbyte aligned pair
    localparam int unsigned SEL_MSB       = 11;           // register select bits 11..3
    localparam int unsigned SEL_LSB       = 3;

    // ============================================================
    // control word field positions
    localparam int unsigned CTL_COP_ON_POS  = 0;          // coprocessor_on_bit
    localparam int unsigned CTL_DET_ONLY_POS = 1;         // detached-only bit
    localparam logic        CTL_COP_ON_RST  = 1'b0;
    localparam logic        CTL_DET_ONLY_RST = 1'b0;

    // ============================================================
    // page offsets, little-endian forms (big-endian adds be_adj)
    localparam logic [11:0] OFS_BND_BASE      = 12'h000;  // loop_boundary_array_base
    localparam logic [11:0] OFS_BND_MASK      = 12'hf87;  // bits that must match: 11-8, 7, 2-0
    localparam logic [11:0] OFS_GET_ITER      = 12'hf60;
    localparam logic [11:0] OFS_NEW_CURRENT   = 12'hfc0;
    localparam logic [11:0] OFS_STATE_WORD    = 12'hfc8;
    localparam logic [11:0] OFS_STATE_CLR_IN  = 12'hfd0;
    localparam logic [11:0] OFS_STATE_NESTED  = 12'hfd8;
    localparam logic [11:0] OFS_CLEAR_LOOP    = 12'hfe8;
    localparam logic [11:0] OFS_UNIT_VERSION  = 12'hff8;
    localparam logic [11:0] OFS_BE_ADJ        = 12'h004;

    // ============================================================
    // state word bit positions
    localparam int unsigned ST_IN_LOOP_POS  = 0;
    localparam int unsigned ST_NESTED_POS   = 1;
    localparam int unsigned ST_DETACHED_POS = 2;

    // ============================================================
    // reset values and identity
    localparam logic [31:0] ITER_RST        = 32'h0000_0000;
    localparam logic [31:0] UNIT_VERSION_VAL = 32'h0000_0001; // arbitrary value

    // ============================================================
    // decoded register selection
    typedef enum logic [3:0] {
        DLSU_SEL_NONE     = 4'b0000,
        DLSU_SEL_BND      = 4'b0001,
        DLSU_SEL_GET_ITER = 4'b0010,
        DLSU_SEL_NEWCUR   = 4'b0011,
        DLSU_SEL_STATE    = 4'b0100,
        DLSU_SEL_CLR_IN   = 4'b0101,
        DLSU_SEL_NESTED   = 4'b0110,
        DLSU_SEL_CLR_LOOP = 4'b0111,
        DLSU_SEL_VERSION  = 4'b1000
    } dlsu_sel_t;

endpackage : dlsu_pkg

// ### rtl/dlsu_bnd_mem.sv
`timescale 1ns/100ps

// boundary register array; read data registered to give load latency
module dlsu_bnd_mem
    import dlsu_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 srst_in,
    // write port
    input  wire logic                 wr_en_in,
    input  wire logic [BND_IDX_W-1:0] wr_idx_in,
    input  wire logic [DATA_W-1:0]    wr_data_in,
    // read port
    input  wire logic [BND_IDX_W-1:0] rd_idx_in,
    output logic      [DATA_W-1:0]    rd_data_out
);

    logic [DATA_W-1:0] mem_ff [BND_DEPTH];

    // storage; no reset so it maps to plain ram
    always_ff @(posedge sys_clk_in) begin
        if (wr_en_in) begin
            mem_ff[wr_idx_in] <= wr_data_in;
        end
    end

    // registered read
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= mem_ff[rd_idx_in];
        end
    end

endmodule : dlsu_bnd_mem

// ### rtl/dlsu_top.sv
`timescale 1ns/100ps

// Functional notes
// - after reset the unit is off: coprocessor-on and detached-only bits cleared
// - while active every access to the user page is served here, no bus cycle
// - region is two pages on an 8 kbyte boundary at the control base field
// - upper supervisor page accesses leave the unit alone and go to memory
// - page match uses the untranslated virtual address
// - unit accesses missing the translation buffer load no page-table entry
// - 32-bit iteration counter plus in-loop, nested, detached at status bits 0..2
// - detached bit always mirrors the control detached-only bit
// - address bits 11..3 select the register; accesses may update counter and bits
// - undecoded loads return zero, undecoded stores change nothing
// - little endian needs bits 2..0 zero; big endian needs bit 2 set
// - read data usable two instructions later; immediate use stalls one clock
// - boundary array at bits 11-7 zero, index from bits 6..3
// - named registers at bits 11-8 all ones, big-endian forms add four
module dlsu_top
    import dlsu_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              srst_in,
    // control word (written by the core's control-register path)
    input  wire logic              ctl_wr_in,
    input  wire logic              ctl_cop_on_in,
    input  wire logic              ctl_det_only_in,
    input  wire logic [31:13]      ctl_base_in,
    input  wire logic              big_endian_bit_in,
    // core load/store path
    input  wire logic              acc_valid_in,
    input  wire logic              acc_write_in,
    input  wire logic [ADDR_W-1:0] acc_vaddr_in,
    input  wire logic [DATA_W-1:0] acc_wdata_in,
    input  wire logic              next_uses_load_in,
    // answers to the core
    output logic                   acc_hit_out,
    output logic                   ext_bus_req_out,
    output logic                   tlb_fill_inhibit_out,
    output logic                   rd_valid_out,
    output logic [DATA_W-1:0]      rd_data_out,
    output logic                   stall_out,
    // observed state
    output logic                   active_out,
    output logic [DATA_W-1:0]      iter_count_out,
    output logic [2:0]             state_bits_out
);

    // ============================================================
    // control register
    logic              cop_on_ff;
    logic              det_only_ff;
    logic [31:13]      base_ff;

    // reset leaves the unit disabled
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            cop_on_ff   <= CTL_COP_ON_RST;
            det_only_ff <= CTL_DET_ONLY_RST;
            base_ff     <= '0;
        end else if (ctl_wr_in) begin
            cop_on_ff   <= ctl_cop_on_in;
            det_only_ff <= ctl_det_only_in;
            base_ff     <= ctl_base_in;
        end
    end

    // ============================================================
    // page match and decode
    logic        active;
    logic        region_hit;
    logic        user_page;
    logic        unit_acc;
    logic [11:0] ofs;
    logic [11:0] be_adj;
    dlsu_sel_t   sel;

    // both enable bits are needed; one alone behaves as disabled
    assign active     = cop_on_ff && det_only_ff;
    // virtual address only, no translation in the path
    assign region_hit = (acc_vaddr_in[31:REGION_LSB] == base_ff);
    assign user_page  = !acc_vaddr_in[PAGE_LSB];
    assign unit_acc   = acc_valid_in && active && region_hit && user_page;
    assign ofs        = acc_vaddr_in[11:0];
    assign be_adj     = big_endian_bit_in ? OFS_BE_ADJ : 12'h000;

    // decode a page offset under the current endian mode
    function automatic dlsu_sel_t decode_sel(input logic [11:0] o, input logic [11:0] adj,
                                             input logic be);
        dlsu_sel_t s;
        s = DLSU_SEL_NONE;
        // bits 2..0 must be 000 (le) or 100 (be); bit 3 belongs to the index
        if (((o & OFS_BND_MASK) == OFS_BND_BASE + adj)) begin
            s = DLSU_SEL_BND;
        end else if (o == OFS_GET_ITER + adj) begin
            s = DLSU_SEL_GET_ITER;
        end else if (o == OFS_NEW_CURRENT + adj) begin
            s = DLSU_SEL_NEWCUR;
        end else if (o == OFS_STATE_WORD + adj) begin
            s = DLSU_SEL_STATE;
        end else if (o == OFS_STATE_CLR_IN + adj) begin
            s = DLSU_SEL_CLR_IN;
        end else if (o == OFS_STATE_NESTED + adj) begin
            s = DLSU_SEL_NESTED;
        end else if (o == OFS_CLEAR_LOOP + adj) begin
            s = DLSU_SEL_CLR_LOOP;
        end else if (o == OFS_UNIT_VERSION + adj) begin
            s = DLSU_SEL_VERSION;
        end
        if (be != adj[2]) begin
            s = DLSU_SEL_NONE;
        end
        return s;
    endfunction : decode_sel

    assign sel = decode_sel(ofs, be_adj, big_endian_bit_in);

    // bus suppression and translation-buffer inhibit
    assign acc_hit_out          = unit_acc;
    assign ext_bus_req_out      = acc_valid_in && !unit_acc;
    assign tlb_fill_inhibit_out = unit_acc;

    // ============================================================
    // iteration counter and state bits
    logic [DATA_W-1:0] iter_ff;
    logic              in_loop_ff;
    logic              nested_ff;
    logic [2:0]        state_bits;

    // detached follows the control bit combinationally
    assign state_bits = {det_only_ff, nested_ff, in_loop_ff};

    // access side effects; exact per-register counter rules live elsewhere,
    // here a get load advances the count and both clear ops drop the in-loop flag
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            iter_ff    <= ITER_RST;
            in_loop_ff <= 1'b0;
            nested_ff  <= 1'b0;
        end else if (unit_acc) begin
            if (acc_write_in) begin
                case (sel)
                    DLSU_SEL_NEWCUR: begin
                        iter_ff    <= acc_wdata_in;
                        in_loop_ff <= 1'b1;
                    end
                    DLSU_SEL_STATE: begin
                        in_loop_ff <= acc_wdata_in[ST_IN_LOOP_POS];
                        nested_ff  <= acc_wdata_in[ST_NESTED_POS];
                    end
                    DLSU_SEL_CLR_LOOP: begin
                        in_loop_ff <= 1'b0;
                    end
                    default: begin
                        // undecoded stores change nothing
                    end
                endcase
            end else begin
                case (sel)
                    DLSU_SEL_GET_ITER: begin
                        iter_ff <= iter_ff + 32'h0000_0001;
                    end
                    DLSU_SEL_CLR_IN: begin
                        in_loop_ff <= 1'b0;
                    end
                    default: begin
                        // plain reads have no side effect
                    end
                endcase
            end
        end
    end

    // ============================================================
    // boundary array
    logic              bnd_wr;
    logic [DATA_W-1:0] bnd_rdata;
    logic [BND_IDX_W-1:0] bnd_idx;

    assign bnd_idx = acc_vaddr_in[6:3];
    assign bnd_wr  = unit_acc && acc_write_in && (sel == DLSU_SEL_BND);

    dlsu_bnd_mem u_bnd_mem (
        .sys_clk_in  (sys_clk_in),
        .srst_in     (srst_in),
        .wr_en_in    (bnd_wr),
        .wr_idx_in   (bnd_idx),
        .wr_data_in  (acc_wdata_in),
        .rd_idx_in   (bnd_idx),
        .rd_data_out (bnd_rdata)
    );

    // ============================================================
    // read path: one register stage, like a data cache hit
    logic              rd_valid_ff;
    logic              rd_is_bnd_ff;
    logic [DATA_W-1:0] rd_word_ff;
    logic [DATA_W-1:0] nxt_rd_word;
    logic              load_now;

    assign load_now = unit_acc && !acc_write_in;

    // select the word; anything undecoded reads zero
    always_comb begin
        nxt_rd_word = '0;
        case (sel)
            DLSU_SEL_GET_ITER: nxt_rd_word = iter_ff;
            DLSU_SEL_NEWCUR:   nxt_rd_word = iter_ff;
            DLSU_SEL_STATE,
            DLSU_SEL_CLR_IN,
            DLSU_SEL_NESTED:   nxt_rd_word = {29'h0, state_bits};
            DLSU_SEL_VERSION:  nxt_rd_word = UNIT_VERSION_VAL;
            default:           nxt_rd_word = '0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rd_valid_ff  <= 1'b0;
            rd_is_bnd_ff <= 1'b0;
            rd_word_ff   <= '0;
        end else begin
            rd_valid_ff  <= load_now;
            rd_is_bnd_ff <= load_now && (sel == DLSU_SEL_BND);
            rd_word_ff   <= load_now ? nxt_rd_word : '0;
        end
    end

    assign rd_valid_out = rd_valid_ff;
    assign rd_data_out  = rd_is_bnd_ff ? bnd_rdata : rd_word_ff;
    // a consumer in the very next instruction waits one clock
    assign stall_out    = load_now && next_uses_load_in;

    // observed state
    assign active_out     = active;
    assign iter_count_out = iter_ff;
    assign state_bits_out = state_bits;

    // ============================================================
    // assertions
    sequence s_unit_load;
        acc_valid_in && active && region_hit && user_page && !acc_write_in;
    endsequence

    sequence s_unit_store;
        acc_valid_in && active && region_hit && user_page && acc_write_in;
    endsequence

    sequence s_get_load;
        s_unit_load ##0 (sel == DLSU_SEL_GET_ITER);
    endsequence

    a_reset_disabled: assert property (@(posedge sys_clk_in)
        srst_in |=> !active_out)
        else $error("unit not disabled after reset");

    a_page_no_bus: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (acc_valid_in && active && region_hit && !acc_vaddr_in[12]) |-> !ext_bus_req_out)
        else $error("bus cycle on unit page");

    a_upper_page_pass: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (acc_valid_in && acc_vaddr_in[12]) |-> (ext_bus_req_out && !acc_hit_out))
        else $error("upper page not passed out");

    a_off_passes_out: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (acc_valid_in && !(cop_on_ff && det_only_ff)) |-> ext_bus_req_out ##1
        $stable(iter_count_out))
        else $error("disabled unit took an access");

    a_no_tlb_fill: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        acc_hit_out |-> tlb_fill_inhibit_out)
        else $error("translation fill not inhibited");

    a_detached_mirror: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        state_bits_out[ST_DETACHED_POS] == det_only_ff)
        else $error("detached bit does not mirror control");

    a_undecoded_zero: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (s_unit_load and (sel == DLSU_SEL_NONE)) |=> (rd_valid_out && rd_data_out == '0))
        else $error("undecoded load not zero");

    a_load_latency: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        s_unit_load |=> rd_valid_out ##1 !rd_valid_out || $past(load_now))
        else $error("load data not one clock later");

    a_newcur_store: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (unit_acc && acc_write_in && sel == DLSU_SEL_NEWCUR)
        |=> (iter_count_out == $past(acc_wdata_in) && state_bits_out[0]))
        else $error("counter store not taken");

    a_be_bit2: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (sel != DLSU_SEL_NONE) |-> (acc_vaddr_in[2] == big_endian_bit_in))
        else $error("endian bit two mismatch");

    // a get load hands out the old count, so the count moves on by exactly one
    a_get_advance: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        s_get_load |=> (iter_count_out == $past(iter_count_out) + 32'h0000_0001))
        else $error("get load did not advance count");

    a_clear_loop: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (s_unit_store ##0 (sel == DLSU_SEL_CLR_LOOP)) |=> !state_bits_out[ST_IN_LOOP_POS])
        else $error("clear loop store left in-loop set");

    a_region_miss: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (acc_valid_in && (acc_vaddr_in[31:REGION_LSB] != base_ff))
        |-> (ext_bus_req_out && !acc_hit_out))
        else $error("foreign region served by unit");

    // the freeze covers one clock only: the data must stand right after it
    a_stall_one_clk: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        stall_out |=> rd_valid_out)
        else $error("stalled consumer saw no data");

endmodule : dlsu_top

// ### verification/dlsu_core_model.sv
`timescale 1ns/100ps

// ============================================================
// core load/store path model: control writes and word accesses
module dlsu_core_model
    import dlsu_pkg::*;
(
    // clock
    input  wire logic              sys_clk_in,
    // control word
    output logic                   ctl_wr_out,
    output logic                   ctl_cop_on_out,
    output logic                   ctl_det_only_out,
    output logic [31:13]           ctl_base_out,
    output logic                   big_endian_bit_out,
    // access request
    output logic                   acc_valid_out,
    output logic                   acc_write_out,
    output logic [ADDR_W-1:0]      acc_vaddr_out,
    output logic [DATA_W-1:0]      acc_wdata_out,
    output logic                   next_uses_load_out,
    // answers
    input  wire logic              acc_hit_in,
    input  wire logic              ext_bus_req_in,
    input  wire logic              tlb_fill_inhibit_in,
    input  wire logic              rd_valid_in,
    input  wire logic [DATA_W-1:0] rd_data_in,
    input  wire logic              stall_in
);
    logic              hit_s, ext_s, tlb_s, rdv_s, stl_s, ken_s;
    logic [DATA_W-1:0] rdd_s;
    logic              cache_enable_input_n;

    // system logic keeps reserved-region bus traffic out of caches; nothing
    // on this path translates, so the region is matched on the raw address
    assign cache_enable_input_n = acc_valid_out && ext_bus_req_in &&
                                  (acc_vaddr_out[31:13] == ctl_base_out);

    // idle values at time zero
    initial begin
        {ctl_wr_out, ctl_cop_on_out, ctl_det_only_out, big_endian_bit_out} = 4'h0;
        {acc_valid_out, acc_write_out, next_uses_load_out} = 3'h0;
        ctl_base_out = '0;
        acc_vaddr_out = '0;
        acc_wdata_out = '0;
    end

    // one control write, then four quiet cycles before any access
    task automatic set_ctl(input logic cop, det, be, input logic [31:13] base);
        @(posedge sys_clk_in);
        #1;
        ctl_wr_out = 1'b1;
        ctl_cop_on_out = cop;
        ctl_det_only_out = det;
        ctl_base_out = base;
        big_endian_bit_out = be;
        @(posedge sys_clk_in);
        #1;
        ctl_wr_out = 1'b0;
        repeat (4) @(posedge sys_clk_in);
    endtask : set_ctl

    // one integer word access; idle address and data are inverted so stale
    // values never look valid
    task automatic acc(input logic wr, input logic [31:0] a, d, input logic nu);
        @(posedge sys_clk_in);
        #1;
        acc_valid_out = 1'b1;
        acc_write_out = wr;
        acc_vaddr_out = a;
        acc_wdata_out = d;
        next_uses_load_out = nu;
        #2;
        hit_s = acc_hit_in;
        ext_s = ext_bus_req_in;
        tlb_s = tlb_fill_inhibit_in;
        stl_s = stall_in;
        ken_s = cache_enable_input_n;
        @(posedge sys_clk_in);
        #1;
        acc_valid_out = 1'b0;
        next_uses_load_out = 1'b0;
        acc_vaddr_out = ~a;
        acc_wdata_out = ~d;
        rdv_s = rd_valid_in;
        rdd_s = rd_data_in;
        stl_s = stl_s | stall_in;
    endtask : acc
endmodule : dlsu_core_model

// ### verification/testbench.sv
`timescale 1ns/100ps

// ============================================================
// self-checking bench for the loop sync unit
module testbench
    import dlsu_pkg::*;
;
    localparam logic [31:0] BASE = 32'h2468_a000; // 8 kbyte aligned
    logic        sys_clk, srst, cw, cc, cd, be, av, aw, nu;
    logic        hit, ext, tlb, rdv, stl, act;
    logic [31:13] cb;
    logic [31:0] va, wd, rdd, itr, exp_iter;
    logic [2:0]  stb;
    int          bad_count, cmp_count;

    dlsu_top dut_u (.sys_clk_in(sys_clk), .srst_in(srst), .ctl_wr_in(cw),
        .ctl_cop_on_in(cc), .ctl_det_only_in(cd), .ctl_base_in(cb),
        .big_endian_bit_in(be), .acc_valid_in(av), .acc_write_in(aw),
        .acc_vaddr_in(va), .acc_wdata_in(wd), .next_uses_load_in(nu),
        .acc_hit_out(hit), .ext_bus_req_out(ext), .tlb_fill_inhibit_out(tlb),
        .rd_valid_out(rdv), .rd_data_out(rdd), .stall_out(stl),
        .active_out(act), .iter_count_out(itr), .state_bits_out(stb));

    dlsu_core_model core_u (.sys_clk_in(sys_clk), .ctl_wr_out(cw),
        .ctl_cop_on_out(cc), .ctl_det_only_out(cd), .ctl_base_out(cb),
        .big_endian_bit_out(be), .acc_valid_out(av), .acc_write_out(aw),
        .acc_vaddr_out(va), .acc_wdata_out(wd), .next_uses_load_out(nu),
        .acc_hit_in(hit), .ext_bus_req_in(ext), .tlb_fill_inhibit_in(tlb),
        .rd_valid_in(rdv), .rd_data_in(rdd), .stall_in(stl));

    // 250 MHz clock
    initial sys_clk = 1'b0;
    always #2 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    // page-relative word store and load with data compare
    task automatic wr(input logic [12:0] o, input logic [31:0] d);
        core_u.acc(1'b1, BASE + 32'(o), d, 1'b0);
    endtask : wr
    task automatic rd(input logic [12:0] o, input logic [31:0] e, input string nm);
        core_u.acc(1'b0, BASE + 32'(o), 32'h0, 1'b0);
        chk(nm, e, core_u.rdd_s);
    endtask : rd

    task automatic t_reset();
        chk("active", 32'h0, 32'(act));
        chk("state", 32'h0, 32'(stb));
        chk("iter", 32'h0, itr);
    endtask : t_reset

    // a clear enable sends the page to the bus; detached bit still mirrors
    task automatic t_off();
        core_u.set_ctl(1'b1, 1'b0, 1'b0, BASE[31:13]);
        wr(13'hfc0, 32'h55);
        chk("ext off", 32'h1, 32'(core_u.ext_s));
        chk("iter off", 32'h0, itr);
        core_u.set_ctl(1'b0, 1'b1, 1'b0, BASE[31:13]);
        core_u.acc(1'b0, BASE + 32'hf60, 32'h0, 1'b0);
        chk("hit off", 32'h0, 32'(core_u.hit_s));
        chk("det mirror", 32'h4, 32'(stb));
    endtask : t_off

    // counter load, fetch-and-increment across the 32-bit wrap
    task automatic t_counter();
        core_u.set_ctl(1'b1, 1'b1, 1'b0, BASE[31:13]);
        chk("active", 32'h1, 32'(act));
        wr(13'hfc0, 32'hffff_fffe);
        chk("hit", 32'h1, 32'(core_u.hit_s));
        chk("no bus", 32'h0, 32'(core_u.ext_s));
        chk("tlb inhibit", 32'h1, 32'(core_u.tlb_s));
        chk("in loop", 32'h5, 32'(stb));
        rd(13'hf60, 32'hffff_fffe, "get iter");
        rd(13'hf60, 32'hffff_ffff, "get iter");
        chk("wrap", 32'h0, itr);
        rd(13'hff8, UNIT_VERSION_VAL, "version");
    endtask : t_counter

    task automatic t_state();
        wr(13'hfc8, 32'h2);
        rd(13'hfc8, 32'h6, "state word");
        rd(13'hfd8, 32'h6, "nested view");
        wr(13'hfc0, 32'h5);
        rd(13'hfc0, 32'h5, "new current");
        wr(13'hfe8, 32'h0);
        chk("clear loop", 32'h6, 32'(stb));
        wr(13'hfc0, 32'h5);
        rd(13'hfd0, 32'h7, "clear in read");
        chk("clear in", 32'h6, 32'(stb));
        exp_iter = 32'h5;
    endtask : t_state

    task automatic t_array();
        for (int i = 0; i < 16; i++) wr(13'(i << 3), 32'h1000 + i);
        for (int i = 0; i < 16; i++) rd(13'(i << 3), 32'h1000 + i, "array");
    endtask : t_array

    // undecoded and wrong-endian places, upper page and foreign region
    task automatic t_refuse();
        rd(13'h080, 32'h0, "undecoded");
        rd(13'hf64, 32'h0, "le bit2");
        wr(13'h100, 32'h77);
        wr(13'h1fc0, 32'h77);
        chk("upper ext", 32'h1, 32'(core_u.ext_s));
        chk("no cache", 32'h1, 32'(core_u.ken_s));
        core_u.acc(1'b1, BASE + 32'h2fc0, 32'h77, 1'b0);
        chk("region ext", 32'h1, 32'(core_u.ext_s));
        chk("cache ok", 32'h0, 32'(core_u.ken_s));
        chk("iter kept", exp_iter, itr);
    endtask : t_refuse

    task automatic t_be();
        core_u.set_ctl(1'b1, 1'b1, 1'b1, BASE[31:13]);
        rd(13'hf64, exp_iter, "be get");
        exp_iter++;
        rd(13'hf60, 32'h0, "be bit2");
        rd(13'hffc, UNIT_VERSION_VAL, "be version");
        rd(13'h02c, 32'h1005, "be array");
        core_u.set_ctl(1'b1, 1'b1, 1'b0, BASE[31:13]);
    endtask : t_be

    task automatic t_stall();
        core_u.acc(1'b0, BASE + 32'hf60, 32'h0, 1'b1);
        chk("stall", 32'h1, 32'(core_u.stl_s));
        chk("rd valid", 32'h1, 32'(core_u.rdv_s));
        core_u.acc(1'b0, BASE + 32'hf60, 32'h0, 1'b0);
        chk("no stall", 32'h0, 32'(core_u.stl_s));
        chk("iter", exp_iter + 32'h2, itr);
        core_u.set_ctl(1'b1, 1'b0, 1'b0, BASE[31:13]);
        chk("det off", 32'h0, 32'(stb[2]));
        chk("inactive", 32'h0, 32'(act));
    endtask : t_stall

    // watchdog sized well above the run length
    initial begin
        #20000;
        bad_count++;
        give_verdict();
    end

    // reset for five cycles, then the scenarios
    initial begin
        bad_count = 0;
        cmp_count = 0;
        exp_iter = 32'h0;
        srst = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_off();
        t_counter();
        t_state();
        t_array();
        t_refuse();
        t_be();
        t_stall();
        give_verdict();
    end
endmodule : testbench
